// [design/cssc_regs.vh]
// Register map, field positions and codes of the clock-synchronous serial channel block
// Notes on behaviour
// - Data output idles high until first transfer
// - Receive-only still shifts out transmit buffer
// - Clock source bit: 0 drives, 1 receives
// - Handshake pin: port, CTS input or RTS
// - Receive recovery: RE off, 000b, 001b, RE
// - Transmit recovery: 000b, 001b, then write TE
// - Polarity picks output and sample clock edges
// - Bit order: LSB first or MSB first
// - Continuous receive: buffer read marks data present
// - Continuous receive bits at fixed positions
// - Invert bit flips transmit and read data
// - Channel 1 internal clock picks clock pin
// - Unused alternate clock pin holds idle level
// - CTS low starts; high stops before next frame
// - RTS low when ready, high at first fall
// - Channel 0 split: RTS own, CTS borrowed
// - Split use removes channel 1 handshake function
// - Internal clock is fj/2(n+1), 8-bit frames
// - Reception needs RE, TE and data present
// - Overrun on 7th bit with unread buffer
`ifndef CSSC_REGS_VH
`define CSSC_REGS_VH

// ==========================================================
// Address map: paddr[7:5] picks the channel, paddr[4:0] the word
`define CSSC_SHARED_CH 3'h3
`define CSSC_OFF_MODE 5'h00
`define CSSC_OFF_CTL0 5'h04
`define CSSC_OFF_CTL1 5'h08
`define CSSC_OFF_BAUD 5'h0c
`define CSSC_OFF_TXBUF 5'h10
`define CSSC_OFF_RXBUF 5'h14
`define CSSC_OFF_SHARED 5'h00

// ==========================================================
// Mode register fields and codes
`define CSSC_MODE_SMD 2:0
`define CSSC_MODE_CLOCK_SOURCE_SELECT 3
`define CSSC_SMD_OFF 3'h0
`define CSSC_SMD_SYNC 3'h1

// ==========================================================
// Control register 0 fields
`define CSSC_C0_SRC 1:0
`define CSSC_C0_KIND 2
`define CSSC_C0_DIS 4
`define CSSC_C0_POL 6
`define CSSC_C0_ORDER 7

// ==========================================================
// Control register 1 fields
`define CSSC_C1_TE 0
`define CSSC_C1_TI 1
`define CSSC_C1_RE 2
`define CSSC_C1_RI 3
`define CSSC_C1_UPPER 7:4
`define CSSC_C1_RRM2 5
`define CSSC_C1_INV 6

// ==========================================================
// Shared control and receive buffer fields
`define CSSC_SH_RRM0 2
`define CSSC_SH_RRM1 3
`define CSSC_SH_ALTSEL 4
`define CSSC_SH_MULTI 5
`define CSSC_SH_SPLIT 6
`define CSSC_RB_OER 12

// ==========================================================
// Reset values
`define CSSC_MODE_RST 4'h0
`define CSSC_C0_RST 8'h10
`define CSSC_C1_RST 8'h02
`define CSSC_ZERO8 8'h00
`define CSSC_ZERO32 32'h0000_0000

// ==========================================================
// Prescaler selections and masks
`define CSSC_PRE_F1 2'h0
`define CSSC_PRE_F2 2'h1
`define CSSC_PRE_F8 2'h2
`define CSSC_PRE_M2 5'h01
`define CSSC_PRE_M8 5'h07
`define CSSC_PRE_M32 5'h1f

// ==========================================================
// Frame bit counts
`define CSSC_OVR_BIT 3'h6
`define CSSC_LAST_BIT 3'h7

`endif

// [design/cssc_top.v]
// Three clock-synchronous serial channels with an APB register slave
`timescale 1ns/10ps
`include "cssc_regs.vh"

module cssc_top (
	// APB clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Serial data pins, one per channel
	output wire [2:0] serial_out_pin,
	input wire [2:0] serial_in_pin,
	// Transfer clock pins
	input wire [2:0] transfer_clock_pin_in,
	output wire [2:0] transfer_clock_pin_out,
	output wire [2:0] transfer_clock_pin_oe_n,
	// Handshake pins
	input wire [2:0] handshake_pin_in,
	output wire [2:0] handshake_pin_out,
	output wire [2:0] handshake_pin_oe_n,
	// Channel 1 second clock pin
	output reg alternate_clock_output,
	output reg alternate_clock_output_oe_n
);

	// ==========================================================
	// Bus phases and shared state
	reg [4:0] pre_cnt_ff;
	reg [7:0] shared_ff;
	reg [31:0] nxt_prdata;
	reg nxt_hit;
	wire setup_acc;
	wire commit;
	wire wr_commit;
	wire rd_commit;
	wire [2:0] a_ch;
	wire [4:0] a_off;
	wire [2:0] ch_hit;
	wire [31:0] ch_rd [0:2];
	wire [7:0] c0_arr [0:2];
	wire [2:0] sclk_v;
	wire [2:0] drive_int;
	wire multi;
	wire altsel;
	wire split_on;
	wire hs1_off;

	assign setup_acc = psel & penable & ~pready;
	assign commit = psel & penable & pready;
	assign wr_commit = commit & pwrite;
	assign rd_commit = commit & ~pwrite;
	assign a_ch = paddr[7:5];
	assign a_off = paddr[4:0];
	assign multi = shared_ff[`CSSC_SH_MULTI];
	assign altsel = shared_ff[`CSSC_SH_ALTSEL];
	// Split needs channel 0 on RTS, channel 1 on CTS and no second clock pin
	assign split_on = shared_ff[`CSSC_SH_SPLIT] & ~c0_arr[0][`CSSC_C0_DIS] & c0_arr[0][`CSSC_C0_KIND] &
		~c0_arr[1][`CSSC_C0_DIS] & ~c0_arr[1][`CSSC_C0_KIND] & ~multi;
	// Channel 1 gives up its handshake pin to the split CTS or to the second clock
	assign hs1_off = split_on | multi;

	// ==========================================================
	// APB slave: one wait state, read data captured with pready
	always @* begin
		nxt_prdata = `CSSC_ZERO32;
		nxt_hit = 1'b1;
		if (a_ch == `CSSC_SHARED_CH && a_off == `CSSC_OFF_SHARED) begin
			nxt_prdata[7:0] = shared_ff;
		end else if (ch_hit[0]) begin
			nxt_prdata = ch_rd[0];
		end else if (ch_hit[1]) begin
			nxt_prdata = ch_rd[1];
		end else if (ch_hit[2]) begin
			nxt_prdata = ch_rd[2];
		end else begin
			nxt_hit = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `CSSC_ZERO32;
			shared_ff <= `CSSC_ZERO8;
			pre_cnt_ff <= 5'h00;
			alternate_clock_output <= 1'b0;
			alternate_clock_output_oe_n <= 1'b1;
		end else begin
			pready <= setup_acc;
			pslverr <= setup_acc & ~nxt_hit;
			if (setup_acc) begin
				prdata <= pwrite ? `CSSC_ZERO32 : nxt_prdata;
			end
			pre_cnt_ff <= pre_cnt_ff + 5'h01;
			if (wr_commit && a_ch == `CSSC_SHARED_CH && a_off == `CSSC_OFF_SHARED) begin
				shared_ff <= pwdata[7:0];
			end
			// Second pin carries the clock or rests at the idle level
			alternate_clock_output_oe_n <= ~(multi & drive_int[1]);
			alternate_clock_output <= altsel ? sclk_v[1] : ~c0_arr[1][`CSSC_C0_POL];
		end
	end

	// ==========================================================
	// Channels
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_ch
			localparam integer CI = g;
			localparam [2:0] CH = CI[2:0];
			localparam IS0 = (CI == 0);
			localparam IS1 = (CI == 1);
			localparam IS2 = (CI == 2);
			localparam integer RRM_IX = IS0 ? `CSSC_SH_RRM0 : `CSSC_SH_RRM1;

			reg [3:0] mode_ff;
			reg [7:0] c0_ff;
			reg [7:0] c1_ff;
			reg [7:0] brg_ff;
			reg [7:0] tb_ff;
			reg [7:0] rb_ff;
			reg oer_ff;
			reg st_ff;
			reg [2:0] cnt_ff;
			reg [7:0] txs_ff;
			reg [7:0] rxs_ff;
			reg [7:0] bcnt_ff;
			reg sclk_ff;
			reg cprev_ff;
			reg fell_ff;
			reg so_ff;
			reg ckout_ff;
			reg ckoe_n_ff;
			reg hsout_ff;
			reg hsoe_n_ff;
			reg fj;
			reg [31:0] rdv;
			wire sel;
			wire sync;
			wire intc;
			wire pol;
			wire idle;
			wire inv;
			wire msb;
			wire rrm;
			wire half;
			wire ext_chg;
			wire lead;
			wire trail;
			wire fall;
			wire cts_use;
			wire cts_ok;
			wire rts_use;
			wire rd_rb;
			wire [7:0] rx_next;

			assign sel = (a_ch == CH);
			assign sync = (mode_ff[`CSSC_MODE_SMD] == `CSSC_SMD_SYNC);
			assign intc = ~mode_ff[`CSSC_MODE_CLOCK_SOURCE_SELECT];
			assign pol = c0_ff[`CSSC_C0_POL];
			assign idle = ~pol;
			assign inv = c1_ff[`CSSC_C1_INV];
			assign msb = c0_ff[`CSSC_C0_ORDER];
			assign rrm = IS2 ? c1_ff[`CSSC_C1_RRM2] : shared_ff[RRM_IX];
			assign half = st_ff & intc & fj & (bcnt_ff == `CSSC_ZERO8);
			assign ext_chg = st_ff & ~intc & (transfer_clock_pin_in[g] != cprev_ff);
			// Leading edge leaves the idle level, trailing edge returns to it
			assign lead = intc ? (half & (sclk_ff == idle)) : (ext_chg & (cprev_ff == idle));
			assign trail = intc ? (half & (sclk_ff != idle)) : (ext_chg & (cprev_ff != idle));
			assign fall = pol ? trail : lead;
			assign cts_use = (IS0 && split_on) ? 1'b1 :
				(~c0_ff[`CSSC_C0_DIS] & ~c0_ff[`CSSC_C0_KIND] & ~(IS1 & hs1_off));
			assign cts_ok = ~cts_use | ~((IS0 && split_on) ? handshake_pin_in[1] : handshake_pin_in[g]);
			assign rts_use = ~c0_ff[`CSSC_C0_DIS] & c0_ff[`CSSC_C0_KIND] & ~(IS1 & hs1_off);
			assign rd_rb = rd_commit & sel & (a_off == `CSSC_OFF_RXBUF);
			assign rx_next = msb ? {rxs_ff[6:0], serial_in_pin[g]} : {serial_in_pin[g], rxs_ff[7:1]};

			assign c0_arr[g] = c0_ff;
			assign sclk_v[g] = sclk_ff;
			assign drive_int[g] = sync & intc;
			assign serial_out_pin[g] = so_ff;
			assign transfer_clock_pin_out[g] = ckout_ff;
			assign transfer_clock_pin_oe_n[g] = ckoe_n_ff;
			assign handshake_pin_out[g] = hsout_ff;
			assign handshake_pin_oe_n[g] = hsoe_n_ff;
			assign ch_hit[g] = sel & (a_off == `CSSC_OFF_MODE || a_off == `CSSC_OFF_CTL0 ||
				a_off == `CSSC_OFF_CTL1 || a_off == `CSSC_OFF_BAUD || a_off == `CSSC_OFF_TXBUF ||
				a_off == `CSSC_OFF_RXBUF);
			assign ch_rd[g] = rdv;

			// Prescaled count source for the baud divider
			always @* begin
				case (c0_ff[`CSSC_C0_SRC])
					`CSSC_PRE_F1: fj = 1'b1;
					`CSSC_PRE_F2: fj = ((pre_cnt_ff & `CSSC_PRE_M2) == `CSSC_PRE_M2);
					`CSSC_PRE_F8: fj = ((pre_cnt_ff & `CSSC_PRE_M8) == `CSSC_PRE_M8);
					default: fj = (pre_cnt_ff == `CSSC_PRE_M32);
				endcase
			end

			always @* begin
				rdv = `CSSC_ZERO32;
				if (a_off == `CSSC_OFF_MODE) begin
					rdv[3:0] = mode_ff;
				end else if (a_off == `CSSC_OFF_CTL0) begin
					rdv[7:0] = c0_ff;
				end else if (a_off == `CSSC_OFF_CTL1) begin
					rdv[7:0] = c1_ff;
				end else if (a_off == `CSSC_OFF_BAUD) begin
					rdv[7:0] = brg_ff;
				end else if (a_off == `CSSC_OFF_TXBUF) begin
					rdv[7:0] = tb_ff;
				end else if (a_off == `CSSC_OFF_RXBUF) begin
					rdv[7:0] = rb_ff ^ {8{inv}};
					rdv[`CSSC_RB_OER] = oer_ff;
				end
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mode_ff <= `CSSC_MODE_RST;
					c0_ff <= `CSSC_C0_RST;
					c1_ff <= `CSSC_C1_RST;
					brg_ff <= `CSSC_ZERO8;
					tb_ff <= `CSSC_ZERO8;
					rb_ff <= `CSSC_ZERO8;
					oer_ff <= 1'b0;
					st_ff <= 1'b0;
					cnt_ff <= 3'h0;
					txs_ff <= `CSSC_ZERO8;
					rxs_ff <= `CSSC_ZERO8;
					bcnt_ff <= `CSSC_ZERO8;
					sclk_ff <= 1'b1;
					cprev_ff <= 1'b1;
					fell_ff <= 1'b0;
					so_ff <= 1'b1;
					ckout_ff <= 1'b0;
					ckoe_n_ff <= 1'b1;
					hsout_ff <= 1'b1;
					hsoe_n_ff <= 1'b1;
				end else begin
					cprev_ff <= transfer_clock_pin_in[g];
					// Buffer read clears the flag before a frame end can set it again
					if (rd_rb) begin
						c1_ff[`CSSC_C1_RI] <= 1'b0;
					end
					if (!sync) begin
						// Disabled mode aborts any frame and empties both buffers
						st_ff <= 1'b0;
						c1_ff[`CSSC_C1_TI] <= 1'b1;
						c1_ff[`CSSC_C1_RI] <= 1'b0;
						oer_ff <= 1'b0;
						sclk_ff <= idle;
						fell_ff <= 1'b0;
						so_ff <= 1'b1;
					end else if (!st_ff) begin
						bcnt_ff <= brg_ff;
						sclk_ff <= idle;
						fell_ff <= 1'b0;
						// Every frame transmits, so reception rides on the transmit start
						if (c1_ff[`CSSC_C1_TE] && !c1_ff[`CSSC_C1_TI] && cts_ok) begin
							st_ff <= 1'b1;
							cnt_ff <= 3'h0;
							txs_ff <= tb_ff ^ {8{inv}};
							c1_ff[`CSSC_C1_TI] <= 1'b1;
						end
					end else begin
						if (intc && fj) begin
							bcnt_ff <= (bcnt_ff == `CSSC_ZERO8) ? brg_ff : bcnt_ff - 8'h01;
						end
						if (half) begin
							sclk_ff <= ~sclk_ff;
						end
						if (fall) begin
							fell_ff <= 1'b1;
						end
						if (lead) begin
							so_ff <= msb ? txs_ff[7] : txs_ff[0];
							txs_ff <= msb ? {txs_ff[6:0], 1'b0} : {1'b0, txs_ff[7:1]};
						end
						if (trail) begin
							rxs_ff <= rx_next;
							cnt_ff <= cnt_ff + 3'h1;
							if (cnt_ff == `CSSC_OVR_BIT && c1_ff[`CSSC_C1_RE] && c1_ff[`CSSC_C1_RI] && !rd_rb) begin
								oer_ff <= 1'b1;
							end
							if (cnt_ff == `CSSC_LAST_BIT) begin
								st_ff <= 1'b0;
								if (c1_ff[`CSSC_C1_RE]) begin
									rb_ff <= rx_next;
									c1_ff[`CSSC_C1_RI] <= 1'b1;
								end
							end
						end
					end
					// Continuous receive re-arms reception from the buffer read alone
					if (rd_rb && rrm) begin
						c1_ff[`CSSC_C1_TI] <= 1'b0;
					end
					if (wr_commit && sel) begin
						if (a_off == `CSSC_OFF_MODE) begin
							mode_ff <= pwdata[3:0];
						end else if (a_off == `CSSC_OFF_CTL0) begin
							c0_ff <= pwdata[7:0];
						end else if (a_off == `CSSC_OFF_CTL1) begin
							c1_ff[`CSSC_C1_UPPER] <= pwdata[`CSSC_C1_UPPER];
							c1_ff[`CSSC_C1_RE] <= pwdata[`CSSC_C1_RE];
							c1_ff[`CSSC_C1_TE] <= pwdata[`CSSC_C1_TE];
						end else if (a_off == `CSSC_OFF_BAUD) begin
							brg_ff <= pwdata[7:0];
						end else if (a_off == `CSSC_OFF_TXBUF) begin
							tb_ff <= pwdata[7:0];
							c1_ff[`CSSC_C1_TI] <= 1'b0;
						end
					end
					// Clock pin drives only on internal clock; unused channel 1 main pin rests idle
					ckoe_n_ff <= ~(sync & intc);
					ckout_ff <= (IS1 && multi && altsel) ? idle : sclk_ff;
					// RTS low while ready, high from the first falling clock edge of a frame
					hsoe_n_ff <= ~rts_use;
					hsout_ff <= ~(rts_use & sync & c1_ff[`CSSC_C1_RE] & ~c1_ff[`CSSC_C1_RI] &
						~(st_ff & (fell_ff | fall)));
				end
			end
		end
	endgenerate

endmodule

// [dv/cssc_chk.sv]
// Port-level checker for the serial channel block
`timescale 1ns/10ps
module cssc_chk (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Pins
	input wire [2:0] serial_out_pin,
	input wire [2:0] transfer_clock_pin_out,
	input wire [2:0] transfer_clock_pin_oe_n,
	input wire [2:0] handshake_pin_out,
	input wire [2:0] handshake_pin_oe_n,
	input wire alternate_clock_output_oe_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// APB answer
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	ready_timing_a: assert property (psel && !penable |-> ##2 pready) else $error("pready late");
	ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("refused read data");
	rdata_hold_a: assert property (!pready |-> $stable(prdata)) else $error("prdata moved");
	// ==========================================================
	// Pins
	// Checked from the second edge in reset, when the registers have surely taken their reset values
	reset_pins_a: assert property (disable iff (1'b0) !presetn && $past(!presetn) |->
		serial_out_pin == 3'h7 && transfer_clock_pin_oe_n == 3'h7 && handshake_pin_oe_n == 3'h7)
		else $error("pins in reset");
	alt_clock_oe_a: assert property (!alternate_clock_output_oe_n |-> !transfer_clock_pin_oe_n[1])
		else $error("second clock pin without internal clock");
	alt_hs_off_a: assert property (!alternate_clock_output_oe_n |-> handshake_pin_oe_n[1])
		else $error("channel 1 handshake driven");
	rts_rise_a: assert property (!handshake_pin_oe_n[2] && $fell(transfer_clock_pin_out[2])
		|-> ##[0:2] handshake_pin_out[2]) else $error("RTS not raised");
	cover property (pslverr);
	cover property (!alternate_clock_output_oe_n);
	cover property ($fell(handshake_pin_out[2]));
endmodule

bind cssc_top cssc_chk cssc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
	.transfer_clock_pin_out(transfer_clock_pin_out), .transfer_clock_pin_oe_n(transfer_clock_pin_oe_n),
	.handshake_pin_out(handshake_pin_out), .handshake_pin_oe_n(handshake_pin_oe_n),
	.alternate_clock_output_oe_n(alternate_clock_output_oe_n));

// [dv/cssc_peer.sv]
// Far-side serial peripheral model for channel 0
`timescale 1ns/10ps
module cssc_peer (
	// Pins
	input wire sclk,
	input wire sout,
	output logic sin,
	// Setup
	input wire pol,
	input wire msb,
	input wire [7:0] tx,
	input wire load,
	// Observed
	output logic [7:0] rx,
	output logic [7:0] cnt
);
	logic [2:0] idx;
	initial begin
		sin = 1'b0;
		rx = 8'h00;
		cnt = 8'h00;
		idx = 3'h0;
	end
	// Idle line shows the inverse of its last bit, so a stale value cannot pass
	always @(posedge load) begin
		idx = 3'h0;
		cnt = 8'h00;
		sin = ~sin;
	end
	always @(sclk) begin
		if (sclk === pol) begin
			sin = msb ? tx[3'h7 - idx] : tx[idx];
			idx = idx + 3'h1;
		end else begin
			rx = msb ? {rx[6:0], sout} : {sout, rx[7:1]};
			cnt = cnt + 8'h01;
		end
	end
endmodule

// [dv/cssc_tb.sv]
// Self-checking bench for the serial channel block
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench;
	logic pclk, presetn, psel, penable, pwrite, cts_n, load, pol, msb, e;
	logic [7:0] paddr, ptx;
	logic [31:0] pwdata, q;
	int miscompares, n_compared;
	wire [31:0] prdata;
	wire pready, pslverr, alt_o, alt_oe_n, psin;
	wire [2:0] sout, ck_o, ck_oe_n, hs_o, hs_oe_n;
	wire [7:0] prx, pcnt;
	cssc_top cssc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_out_pin(sout), .serial_in_pin({sout[2:1], psin}), .transfer_clock_pin_in(ck_oe_n | ck_o),
		.transfer_clock_pin_out(ck_o), .transfer_clock_pin_oe_n(ck_oe_n),
		.handshake_pin_in({hs_oe_n[2:1] | hs_o[2:1], cts_n}), .handshake_pin_out(hs_o),
		.handshake_pin_oe_n(hs_oe_n), .alternate_clock_output(alt_o), .alternate_clock_output_oe_n(alt_oe_n));
	cssc_peer cssc_peer_i (.sclk(ck_o[0]), .sout(sout[0]), .sin(psin), .pol(pol), .msb(msb), .tx(ptx),
		.load(load), .rx(prx), .cnt(pcnt));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task conclude;
		begin
			$display("Compared %0d, mismatches %0d", n_compared, miscompares);
			if (miscompares == 0 && n_compared > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Arms the far side after setup so polarity changes are not counted as bits
	task arm(input logic p, input logic m, input logic [7:0] t);
		begin
			@(posedge pclk);
			pol <= p;
			msb <= m;
			ptx <= t;
			load <= 1'b1;
			@(posedge pclk);
			load <= 1'b0;
		end
	endtask
	task bits(input logic [7:0] n);
		while (pcnt !== n) @(posedge pclk);
	endtask
	initial begin
		#100000;
		miscompares++;
		conclude;
	end
	initial begin
		{presetn, psel, penable, pwrite, load, pol, msb} = 7'h00;
		{paddr, ptx, pwdata} = 48'h0;
		cts_n = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		bus(0, 8'h04, 0);
		`CHK(q, 32'h0000_0010)
		bus(0, 8'h08, 0);
		`CHK(q, 32'h0000_0002)
		bus(0, 8'h18, 0);
		`CHK({e, q}, 33'h1_0000_0000)
		// Full duplex, LSB first, CTS gating
		bus(1, 8'h0c, 3);
		bus(1, 8'h04, 0);
		bus(1, 8'h00, 1);
		bus(1, 8'h08, 5);
		`CHK({ck_oe_n[0], sout[0]}, 2'h1)
		arm(0, 0, 8'ha5);
		bus(1, 8'h10, 8'h3c);
		repeat (40) @(posedge pclk);
		`CHK(pcnt, 8'h00)
		cts_n <= 1'b0;
		bits(8);
		`CHK(prx, 8'h3c)
		bus(0, 8'h14, 0);
		`CHK(q[7:0], 8'ha5)
		// MSB first, other polarity, inverted data
		bus(1, 8'h04, 8'hd0);
		bus(1, 8'h08, 8'h45);
		repeat (3) @(posedge pclk);
		`CHK(ck_o[0], 1'b0)
		arm(1, 1, 8'h81);
		bus(1, 8'h10, 8'h0f);
		bits(8);
		`CHK(prx, 8'hf0)
		bus(0, 8'h14, 0);
		`CHK(q[7:0], 8'h7e)
		// Back-to-back frames with unread data, then recovery
		bus(1, 8'h04, 8'h10);
		bus(1, 8'h08, 5);
		arm(0, 0, 8'h5a);
		bus(1, 8'h10, 8'h11);
		q = 0;
		while (q[1] !== 1'b1) bus(0, 8'h08, 0);
		bus(1, 8'h10, 8'h22);
		bits(16);
		`CHK(prx, 8'h22)
		bus(0, 8'h14, 0);
		`CHK(q[12], 1'b1)
		bus(1, 8'h08, 1);
		bus(1, 8'h00, 0);
		repeat (3) @(posedge pclk);
		`CHK(sout[0], 1'b1)
		bus(1, 8'h00, 1);
		bus(1, 8'h08, 5);
		bus(0, 8'h14, 0);
		`CHK(q[12], 1'b0)
		bus(0, 8'h08, 0);
		`CHK(q[1], 1'b1)
		// Continuous receive: dummy read starts the frame
		arm(0, 0, 8'h33);
		bus(1, 8'h60, 8'h04);
		bus(0, 8'h14, 0);
		bits(8);
		bus(0, 8'h08, 0);
		`CHK(q[3], 1'b1)
		bus(1, 8'h60, 0);
		// Channel 0 split: own pin turns RTS, CTS comes from channel 1's undriven pin
		bus(1, 8'h04, 8'h04);
		bus(1, 8'h24, 0);
		bus(1, 8'h60, 8'h40);
		arm(0, 0, 8'h00);
		bus(1, 8'h10, 8'h01);
		repeat (40) @(posedge pclk);
		`CHK({hs_oe_n[1:0], pcnt}, 10'h200)
		bus(1, 8'h60, 0);
		bits(8);
		`CHK(prx, 8'h01)
		// Channel 1 second clock pin
		bus(1, 8'h20, 1);
		bus(1, 8'h60, 8'h20);
		repeat (3) @(posedge pclk);
		`CHK({alt_oe_n, alt_o}, 2'h1)
		bus(1, 8'h24, 8'h50);
		repeat (3) @(posedge pclk);
		`CHK(alt_o, 1'b0)
		// Second pin carries the clock while the main pin rests at idle
		bus(1, 8'h60, 8'h30);
		bus(1, 8'h28, 1);
		bus(1, 8'h30, 8'hff);
		e = alt_o;
		q = 0;
		repeat (30) begin
			@(posedge pclk);
			if (alt_o !== e) q++;
			e = alt_o;
			if (ck_o[1] !== 1'b0) q = 32'hff;
		end
		`CHK(q, 32'h10)
		bus(1, 8'h60, 0);
		// Channel 2 RTS
		bus(1, 8'h44, 8'h04);
		bus(1, 8'h40, 1);
		bus(1, 8'h48, 4);
		repeat (3) @(posedge pclk);
		`CHK({hs_oe_n[2], hs_o[2]}, 2'h0)
		bus(1, 8'h48, 5);
		bus(1, 8'h50, 8'h55);
		repeat (30) @(posedge pclk);
		`CHK(hs_o[2], 1'b1)
		bus(1, 8'h44, 8'h10);
		repeat (3) @(posedge pclk);
		`CHK(hs_oe_n[2], 1'b1)
		bus(1, 8'h00, 8'h09);
		repeat (3) @(posedge pclk);
		`CHK(ck_oe_n[0], 1'b1)
		conclude;
	end
endmodule
